// ---- logic/xpc_config.sv ----
`timescale 1ns/10ps
// Operation
// RQ1: Reset pin low disables all outputs; first rank is kept as it was.
// RQ2: Broadcast mode writes the six data bits into all 32 slots.
// RQ3: Serial mode shifts the serial input bit in on each serial clock falling edge.
// RQ4: Each shifted bit leaves the serial output 192 serial clocks later.
// RQ5: Parallel mode writes the six data bits only into the addressed slot.
// RQ6: Strobe high with update low copies the first rank into the second.
// RQ7: Each output selects exactly one of 32 inputs, or none if disabled.
// RQ8: Serial output carries the end of the chain for daisy chaining.
// RQ9: Controller must shift a full image when loading serially.
// RQ10: Serial input is taken on the falling edge of the serial clock.
// RQ11: Stream starts at output 31, enable bit first, select bit 4 down.
// RQ12: A cleared enable bit disables the output and ignores its select.
// RQ13: Parallel and broadcast writes happen on the strobe falling edge.
module xpc_config
	import xpc_pkg::*;
#(
	parameter int FIFO_DEPTH = XPC_FIFO_DEPTH
) (
	input  wire logic                        I_CORE_CLK,
	input  wire logic                        I_RST,
	input  wire logic                        I_SERIAL_CLK,
	input  wire logic                        I_SERIAL_DATA_IN,
	input  wire logic                        I_WRITE_STROBE_N,
	input  wire logic                        I_UPDATE_N,
	input  wire logic                        I_RESET_N,
	input  wire logic                        I_SERIAL_PARALLEL_SELECT,
	input  wire logic [XPC_SLOT_W-1:0]       I_SLOT_CONFIG_BITS,
	input  wire logic [XPC_SEL_W-1:0]        I_OUTPUT_SLOT_SELECT,
	output logic                             O_SERIAL_DATA_OUT,
	output logic [XPC_NUM_OUT-1:0]           O_OUTPUT_ENABLE,
	output logic [XPC_NUM_OUT*XPC_SEL_W-1:0] O_INPUT_SELECT,
	output logic [XPC_GATE_W-1:0]            O_CROSSPOINT_GATE,
	output logic                             O_CMD_READY
);

	generate
		if (FIFO_DEPTH < 2) begin : g_bad_depth
			$error("xpc_config needs a command queue of at least 2");
		end
	endgenerate

	// One slot's gate row: one-hot on the selected input, empty if disabled
	function automatic logic [XPC_NUM_IN-1:0] xpc_gate_row(
		input logic [XPC_SLOT_W-1:0] slot
	);
		logic [XPC_NUM_IN-1:0] row;
		row = '0;
		if (slot[XPC_EN_BIT]) begin
			row = {{(XPC_NUM_IN-1){1'b0}}, 1'b1} << slot[XPC_SEL_W-1:0];
		end
		return row;
	endfunction

	logic [XPC_PIN_W-1:0]   pin_raw;
	logic [XPC_PIN_W-1:0]   sync1_reg;
	logic [XPC_PIN_W-1:0]   sync2_reg;
	logic                   sclk_prev_reg;
	logic                   we_prev_reg;
	logic                   sclk_s;
	logic                   sdin_s;
	logic                   we_s;
	logic                   upd_s;
	logic                   rstn_s;
	logic                   sp_s;
	logic [XPC_SLOT_W-1:0]  data_s;
	logic [XPC_SEL_W-1:0]   addr_s;
	logic                   sclk_fall;
	logic                   we_fall;
	logic                   shift_evt;
	logic                   slot_evt;
	logic                   bcast_evt;
	logic                   cmd_valid;
	logic [XPC_CMD_W-1:0]   cmd_data;
	logic [XPC_KIND_W-1:0]  cmd_kind;
	logic                   q_ready;
	logic                   q_valid;
	logic [XPC_CMD_W-1:0]   q_data;
	logic                   drain_ready;
	logic                   drain;
	logic [XPC_KIND_W-1:0]  q_kind;
	logic [XPC_SEL_W-1:0]   q_addr;
	logic [XPC_SLOT_W-1:0]  q_slot;
	logic                   update_go;
	logic [XPC_CHAIN_W-1:0] rank1_reg;
	logic [XPC_CHAIN_W-1:0] rank2_reg;
	logic [XPC_GATE_W-1:0]  gate_reg;
	logic                   sdo_reg;

	// Every control pin is asynchronous to the core clock
	assign pin_raw = {I_SERIAL_CLK, I_SERIAL_DATA_IN, I_WRITE_STROBE_N,
		I_UPDATE_N, I_RESET_N, I_SERIAL_PARALLEL_SELECT,
		I_SLOT_CONFIG_BITS, I_OUTPUT_SLOT_SELECT};

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sync1_reg <= XPC_SYNC_RST;
			sync2_reg <= XPC_SYNC_RST;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	assign sclk_s = sync2_reg[XPC_PIN_SCLK];
	assign sdin_s = sync2_reg[XPC_PIN_SDIN];
	assign we_s   = sync2_reg[XPC_PIN_WE];
	assign upd_s  = sync2_reg[XPC_PIN_UPD];
	assign rstn_s = sync2_reg[XPC_PIN_RSTN];
	assign sp_s   = sync2_reg[XPC_PIN_SP];
	assign data_s = sync2_reg[XPC_PIN_DATA +: XPC_SLOT_W];
	assign addr_s = sync2_reg[XPC_PIN_ADDR +: XPC_SEL_W];

	// Reset to low so a strobe already low after reset is not an edge
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sclk_prev_reg <= 1'b0;
			we_prev_reg   <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			we_prev_reg   <= we_s;
		end
	end

	assign sclk_fall = sclk_prev_reg & ~sclk_s; // RQ10
	assign we_fall   = we_prev_reg & ~we_s; // RQ13

	// The three loading modes are exclusive: the strobe is high for shifts
	assign shift_evt = rstn_s & ~sp_s & we_s & sclk_fall; // RQ3
	assign slot_evt  = rstn_s & sp_s & we_fall; // RQ5
	assign bcast_evt = rstn_s & ~sp_s & we_fall; // RQ2
	assign cmd_valid = shift_evt | slot_evt | bcast_evt;

	always_comb begin
		cmd_kind = XPC_KIND_SHIFT;
		if (slot_evt) begin
			cmd_kind = XPC_KIND_SLOT;
		end else if (bcast_evt) begin
			cmd_kind = XPC_KIND_BCAST;
		end
	end

	// Shift commands carry the serial bit in the low data position
	assign cmd_data = {cmd_kind, addr_s,
		shift_evt ? {{(XPC_SLOT_W-1){1'b0}}, sdin_s} : data_s};

	// Edges that arrive with the queue full are lost; O_CMD_READY shows it
	assign O_CMD_READY = q_ready;

	xpc_fifo #(
		.WIDTH (XPC_CMD_W),
		.DEPTH (FIFO_DEPTH)
	) u_cmd_fifo (
		.i_clk      (I_CORE_CLK),
		.i_rst      (I_RST),
		.i_wr_valid (cmd_valid),
		.o_wr_ready (q_ready),
		.i_wr_data  (cmd_data),
		.o_rd_valid (q_valid),
		.i_rd_ready (drain_ready),
		.o_rd_data  (q_data)
	);

	// Queued writes wait while the reset pin is low instead of being dropped
	assign drain_ready = rstn_s;
	assign drain       = q_valid & drain_ready;
	assign q_kind      = q_data[XPC_CMD_KIND_LSB +: XPC_KIND_W];
	assign q_addr      = q_data[XPC_CMD_ADDR_LSB +: XPC_SEL_W];
	assign q_slot      = q_data[XPC_CMD_DATA_LSB +: XPC_SLOT_W];

	// Slot k sits at bits 6k+5..6k, so shifting up lands the first bit
	// in the enable of output 31 after a full image
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			rank1_reg <= XPC_RANK_RST;
		end else if (drain) begin
			case (q_kind)
				XPC_KIND_SHIFT: begin
					rank1_reg <= {rank1_reg[XPC_CHAIN_W-2:0], q_slot[0]}; // RQ3 RQ11
				end
				XPC_KIND_SLOT: begin
					for (int k = 0; k < XPC_NUM_OUT; k++) begin
						if (k == int'(q_addr)) begin
							rank1_reg[k*XPC_SLOT_W +: XPC_SLOT_W] <= q_slot; // RQ5
						end
					end
				end
				XPC_KIND_BCAST: begin
					for (int k = 0; k < XPC_NUM_OUT; k++) begin
						rank1_reg[k*XPC_SLOT_W +: XPC_SLOT_W] <= q_slot; // RQ2
					end
				end
				default: begin
					rank1_reg <= rank1_reg;
				end
			endcase
		end
	end

	// The bit leaving the top on a shift is held here, giving 192 shifts
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sdo_reg <= 1'b0;
		end else if (drain && q_kind == XPC_KIND_SHIFT) begin
			sdo_reg <= rank1_reg[XPC_CHAIN_W-1]; // RQ4 RQ8
		end
	end

	assign O_SERIAL_DATA_OUT = sdo_reg;

	// Copy only once the queue is empty so every edge seen before is in
	assign update_go = rstn_s & we_s & ~upd_s & ~q_valid; // RQ6

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST || !rstn_s) begin
			rank2_reg <= XPC_RANK_RST; // RQ1
		end else if (update_go) begin
			rank2_reg <= rank1_reg; // RQ6
		end
	end

	// Gate grid costs one cycle after the second rank, but stays glitch free
	generate
		for (genvar o = 0; o < XPC_NUM_OUT; o++) begin : g_out
			always_ff @(posedge I_CORE_CLK) begin
				if (I_RST || !rstn_s) begin
					gate_reg[o*XPC_NUM_IN +: XPC_NUM_IN] <= '0; // RQ1
				end else begin
					gate_reg[o*XPC_NUM_IN +: XPC_NUM_IN] <=
						xpc_gate_row(rank2_reg[o*XPC_SLOT_W +: XPC_SLOT_W]); // RQ7 RQ12
				end
			end
			assign O_OUTPUT_ENABLE[o] =
				rank2_reg[o*XPC_SLOT_W + XPC_EN_BIT]; // RQ12
			assign O_INPUT_SELECT[o*XPC_SEL_W +: XPC_SEL_W] =
				rank2_reg[o*XPC_SLOT_W +: XPC_SEL_W];
		end
	endgenerate

	assign O_CROSSPOINT_GATE = gate_reg;

endmodule

// ---- logic/xpc_pkg.sv ----
package xpc_pkg;

	// Array shape
	localparam int XPC_NUM_OUT  = 32;
	localparam int XPC_NUM_IN   = 32;
	localparam int XPC_SEL_W    = 5;
	localparam int XPC_SLOT_W   = 6;
	localparam int XPC_EN_BIT   = 5;
	localparam int XPC_CHAIN_W  = XPC_NUM_OUT * XPC_SLOT_W;
	localparam int XPC_GATE_W   = XPC_NUM_OUT * XPC_NUM_IN;

	// Command queue between pin sampling and the first rank
	localparam int XPC_FIFO_DEPTH = 16;
	localparam int XPC_KIND_W     = 2;
	localparam int XPC_CMD_W      = XPC_KIND_W + XPC_SEL_W + XPC_SLOT_W;
	localparam int XPC_CMD_KIND_LSB = XPC_SEL_W + XPC_SLOT_W;
	localparam int XPC_CMD_ADDR_LSB = XPC_SLOT_W;
	localparam int XPC_CMD_DATA_LSB = 0;

	localparam logic [XPC_KIND_W-1:0] XPC_KIND_SHIFT = 2'h1;
	localparam logic [XPC_KIND_W-1:0] XPC_KIND_SLOT  = 2'h2;
	localparam logic [XPC_KIND_W-1:0] XPC_KIND_BCAST = 2'h3;

	// Field positions in the synchronised pin vector
	localparam int XPC_PIN_W     = 17;
	localparam int XPC_PIN_SCLK  = 16;
	localparam int XPC_PIN_SDIN  = 15;
	localparam int XPC_PIN_WE    = 14;
	localparam int XPC_PIN_UPD   = 13;
	localparam int XPC_PIN_RSTN  = 12;
	localparam int XPC_PIN_SP    = 11;
	localparam int XPC_PIN_DATA  = 5;
	localparam int XPC_PIN_ADDR  = 0;

	// Values after reset
	localparam logic [XPC_PIN_W-1:0]   XPC_SYNC_RST  = 17'h00000;
	localparam logic [XPC_CHAIN_W-1:0] XPC_RANK_RST  = '0;
	localparam logic [XPC_GATE_W-1:0]  XPC_GATE_RST  = '0;

endpackage

// ---- logic/xpc_fifo.sv ----
`timescale 1ns/10ps
module xpc_fifo
	import xpc_pkg::*;
#(
	parameter int WIDTH = XPC_CMD_W,
	parameter int DEPTH = XPC_FIFO_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic [WIDTH-1:0]      o_rd_data
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("xpc_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign o_wr_ready = (count_reg != FULL_COUNT);
	assign o_rd_valid = (count_reg != '0);
	assign o_rd_data  = mem_reg[rd_ptr_reg];
	assign push       = i_wr_valid & o_wr_ready;
	assign pop        = o_rd_valid & i_rd_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_wr_data;
		end
	end

	// Pointers wrap naturally because the depth is a power of two
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule

// ---- dv/xpc_config_monitor.sv ----
`timescale 1ns/10ps
module xpc_config_monitor
	import xpc_pkg::*;
#(
	parameter int FIFO_DEPTH = XPC_FIFO_DEPTH
) (
	input wire logic                             I_CORE_CLK,
	input wire logic                             I_RST,
	input wire logic                             I_SERIAL_CLK,
	input wire logic                             I_WRITE_STROBE_N,
	input wire logic                             I_UPDATE_N,
	input wire logic                             I_RESET_N,
	input wire logic                             O_SERIAL_DATA_OUT,
	input wire logic [XPC_NUM_OUT-1:0]           O_OUTPUT_ENABLE,
	input wire logic [XPC_NUM_OUT*XPC_SEL_W-1:0] O_INPUT_SELECT,
	input wire logic [XPC_GATE_W-1:0]            O_CROSSPOINT_GATE
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	function automatic logic [XPC_GATE_W-1:0] grid(
		input logic [XPC_NUM_OUT-1:0] en,
		input logic [XPC_NUM_OUT*XPC_SEL_W-1:0] s);
		grid = '0;
		for (int o = 0; o < XPC_NUM_OUT; o++)
			if (en[o])
				grid[o*XPC_NUM_IN+s[o*XPC_SEL_W+:XPC_SEL_W]] = 1'b1;
	endfunction

	function automatic logic rows_ok(input logic [XPC_GATE_W-1:0] g);
		rows_ok = 1'b1;
		for (int o = 0; o < XPC_NUM_OUT; o++)
			if (!$onehot0(g[o*XPC_NUM_IN+:XPC_NUM_IN]))
				rows_ok = 1'b0;
	endfunction

	// Pins pass a two-stage synchroniser, hence the windows of 3..7 cycles
	property p_rst_en;
		!I_RESET_N [*5] |-> O_OUTPUT_ENABLE == '0;
	endproperty
	a_rst_en: assert property (p_rst_en)
		else $error("output enabled under reset pin");
	property p_rst_keep;
		!I_RESET_N [*6] |=> $stable(O_SERIAL_DATA_OUT);
	endproperty
	a_rst_keep: assert property (p_rst_keep)
		else $error("chain moved under reset pin");
	property p_gate;
		I_RESET_N [*5] |-> O_CROSSPOINT_GATE ==
			grid($past(O_OUTPUT_ENABLE), $past(O_INPUT_SELECT));
	endproperty
	a_gate: assert property (p_gate)
		else $error("gate grid differs from second rank");
	property p_onehot;
		rows_ok(O_CROSSPOINT_GATE);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("output driven by several inputs");
	property p_dis;
		!O_OUTPUT_ENABLE[0] |=> O_CROSSPOINT_GATE[XPC_NUM_IN-1:0] == '0;
	endproperty
	a_dis: assert property (p_dis)
		else $error("disabled output still gated");
	property p_sel_hold;
		$changed(O_INPUT_SELECT) |-> !$past(I_UPDATE_N, 3) ||
			!$past(I_UPDATE_N, 4) || !$past(I_RESET_N, 3);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("select moved without update");
	property p_en_hold;
		!$stable(O_OUTPUT_ENABLE) |-> !$past(I_UPDATE_N, 3) ||
			!$past(I_UPDATE_N, 4) || !$past(I_RESET_N, 3);
	endproperty
	a_en_hold: assert property (p_en_hold)
		else $error("enable moved without update");
	property p_sdo;
		$changed(O_SERIAL_DATA_OUT) |->
			$past(I_SERIAL_CLK, 7) && !$past(I_SERIAL_CLK, 4) ||
			$past(I_WRITE_STROBE_N, 7) && !$past(I_WRITE_STROBE_N, 4);
	endproperty
	a_sdo: assert property (p_sdo)
		else $error("serial out moved without a falling edge");
endmodule

bind xpc_config xpc_config_monitor #(.FIFO_DEPTH(FIFO_DEPTH))
	u_xpc_config_monitor (.I_CORE_CLK, .I_RST, .I_SERIAL_CLK,
	.I_WRITE_STROBE_N, .I_UPDATE_N, .I_RESET_N, .O_SERIAL_DATA_OUT,
	.O_OUTPUT_ENABLE, .O_INPUT_SELECT, .O_CROSSPOINT_GATE);

// ---- dv/xpc_ctl.sv ----
`timescale 1ns/10ps
module xpc_ctl
	import xpc_pkg::*;
(
	input  wire logic             i_clk,
	output logic                  o_sclk,
	output logic                  o_sdin,
	output logic                  o_we_n,
	output logic                  o_upd_n,
	output logic                  o_rst_n,
	output logic                  o_sp,
	output logic [XPC_SLOT_W-1:0] o_data,
	output logic [XPC_SEL_W-1:0]  o_addr
);
	// Serial clock idles high so no stray edge shifts the chain
	initial begin
		{o_sclk, o_sdin, o_we_n, o_upd_n, o_rst_n, o_sp} = 6'h3e;
		{o_data, o_addr} = '0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(input logic sp, input logic [XPC_SEL_W-1:0] a,
		input logic [XPC_SLOT_W-1:0] d);
		@(posedge i_clk);
		o_sp <= sp;
		o_addr <= a;
		o_data <= d;
		cyc(4);
		o_we_n <= 1'b0;
		cyc(4);
		o_we_n <= 1'b1;
		cyc(4);
		o_sp <= 1'b0;
	endtask
	task automatic upd();
		@(posedge i_clk);
		o_upd_n <= 1'b0;
		cyc(8);
		o_upd_n <= 1'b1;
		cyc(4);
	endtask
	task automatic pin_rst(input logic v);
		@(posedge i_clk);
		o_rst_n <= v;
	endtask
	// Data moves only while the clock is high, far from the sampling edge
	task automatic sbit(input logic b);
		o_sdin = b;
		#62.5 o_sclk = 1'b0;
		#62.5 o_sclk = 1'b1;
	endtask
	task automatic img(input logic [XPC_CHAIN_W-1:0] v);
		for (int i = XPC_CHAIN_W-1; i >= 0; i--)
			sbit(v[i]);
	endtask
endmodule

// ---- dv/xpc_config_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
$display("[ERR] %0t output mismatch", $time); end end
module xpc_config_tb
	import xpc_pkg::*;
;
	typedef struct packed {
		logic                   sdo;
		logic [XPC_CHAIN_W-1:0] v;
	} xpc_exp_s;
	logic                             clk, rst, sdo, sclk, sdin;
	logic                             we_n, upd_n, rst_n, sp, rdy;
	logic [XPC_GATE_W-1:0]            gate;
	logic [XPC_SLOT_W-1:0]            data, d;
	logic [XPC_SEL_W-1:0]             addr, a;
	logic [XPC_NUM_OUT-1:0]           en;
	logic [XPC_NUM_OUT*XPC_SEL_W-1:0] sel;
	logic [XPC_CHAIN_W-1:0]           img, v2;
	xpc_exp_s                         e;
	xpc_exp_s                         exp_q[$];
	int                               seed = 93209;
	int                               n_checks = 0;
	int                               bad_count = 0;
	event                             smp;

	xpc_config #(.FIFO_DEPTH(4)) u_xpc_config (
		.I_CORE_CLK(clk), .I_RST(rst), .I_SERIAL_CLK(sclk),
		.I_SERIAL_DATA_IN(sdin), .I_WRITE_STROBE_N(we_n),
		.I_UPDATE_N(upd_n), .I_RESET_N(rst_n),
		.I_SERIAL_PARALLEL_SELECT(sp), .I_SLOT_CONFIG_BITS(data),
		.I_OUTPUT_SLOT_SELECT(addr), .O_SERIAL_DATA_OUT(sdo),
		.O_OUTPUT_ENABLE(en), .O_INPUT_SELECT(sel),
		.O_CROSSPOINT_GATE(gate), .O_CMD_READY(rdy));
	xpc_ctl u_xpc_ctl (.i_clk(clk), .o_sclk(sclk), .o_sdin(sdin),
		.o_we_n(we_n), .o_upd_n(upd_n), .o_rst_n(rst_n), .o_sp(sp),
		.o_data(data), .o_addr(addr));

	function automatic logic [XPC_CHAIN_W-1:0] arr(
		input logic [XPC_CHAIN_W-1:0] v);
		for (int o = 0; o < XPC_NUM_OUT; o++) begin
			arr[XPC_CHAIN_W-XPC_NUM_OUT+o] = v[o*XPC_SLOT_W+XPC_EN_BIT];
			arr[o*XPC_SEL_W+:XPC_SEL_W] = v[o*XPC_SLOT_W+:XPC_SEL_W];
		end
	endfunction
	// Gate grid from an expected enable and select image
	function automatic logic [XPC_GATE_W-1:0] gexp(
		input logic [XPC_CHAIN_W-1:0] v);
		gexp = '0;
		for (int o = 0; o < XPC_NUM_OUT; o++) begin
			if (v[XPC_CHAIN_W-XPC_NUM_OUT+o])
				gexp[o*XPC_NUM_IN+v[o*XPC_SEL_W+:XPC_SEL_W]] = 1'b1;
		end
	endfunction
	task automatic note(input logic k, input logic [XPC_CHAIN_W-1:0] v);
		exp_q.push_back(k ? {1'b1, v} : {1'b0, arr(v)});
		->smp;
		@(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always begin
		@(smp);
		e = exp_q.pop_front();
		if (e.sdo)
			`CHK(sdo, e.v[0])
		else begin
			`CHK({rdy, en, sel}, {1'b1, e.v})
			`CHK(gate, gexp(e.v))
		end
	end
	initial begin
		#400000;
		bad_count++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		u_xpc_ctl.cyc(4);
		d = 6'($random(seed)) | 6'h20;
		u_xpc_ctl.wr(1'b0, 5'($random(seed)), d);
		u_xpc_ctl.upd();
		img = {XPC_NUM_OUT{d}};
		note(1'b0, img);
		for (int k = 0; k < 4; k++) begin
			a = 5'($random(seed));
			d = 6'($random(seed));
			if (k == 0)
				d[XPC_EN_BIT] = 1'b0;
			u_xpc_ctl.wr(1'b1, a, d);
			img[a*XPC_SLOT_W+:XPC_SLOT_W] = d;
			// Two writes share one update to prove the ranks are separate
			if (k[0]) begin
				u_xpc_ctl.upd();
				note(1'b0, img);
			end
		end
		for (int i = 0; i < 6; i++) begin
			img[i*32+:32] = $random(seed);
			v2[i*32+:32] = $random(seed);
		end
		u_xpc_ctl.img(img);
		u_xpc_ctl.upd();
		note(1'b0, img);
		for (int i = XPC_CHAIN_W-1; i >= 0; i--) begin
			u_xpc_ctl.sbit(v2[i]);
			note(1'b1, XPC_CHAIN_W'(img[i]));
		end
		u_xpc_ctl.upd();
		note(1'b0, v2);
		u_xpc_ctl.pin_rst(1'b0);
		u_xpc_ctl.cyc(4);
		u_xpc_ctl.upd();
		note(1'b0, '0);
		u_xpc_ctl.pin_rst(1'b1);
		u_xpc_ctl.cyc(4);
		u_xpc_ctl.upd();
		note(1'b0, v2);
		summarize();
	end
endmodule
